// >>> design/led_seq_consts.vh
// Constants for the LED string fault sequencer.
// Assumes a 20 MHz system clock and comparator levels on all sense inputs.
//
// What this block does
// - Open in-use string: flag and disable it
// - High string with low neighbour: flag short
// - Faulty string off, healthy strings keep running
// - Current limit ends each switch on-phase
// - Overcurrent past fault timer latches off
// - Overvoltage stops switching, resumes when cleared
// - Thermal trip latches whole device off
// - Pull-up on sense pins during diagnostic
// - Low at diagnostic end means unused string
// - Converter starts only after diagnostic ends
// - Extra minimum-sense interval after soft-start
// - Fixed soft-start; start-up bounded in time
// - Sources follow dimming input directly
// - Fault flag low on device faults
// - Usage classification frozen after diagnostic
// - Skip detection on short dimming pulses
// - No short detection during soft-start
`ifndef LED_SEQ_CONSTS_VH
`define LED_SEQ_CONSTS_VH

// =====================================================================
// Clock and timing
`define CLK_MHZ          20
`define T_DIAG_US        1000
`define T_SOFT_US        2000
`define T_MINFB_US       1000
`define T_OC_US          128
`define T_MIN_ON_US      2
// Same spans in clk_sys cycles, sized to the counters that use them
`define DIAG_CYC         16'h4e20
`define SOFT_CYC         16'h9c40
`define MINFB_CYC        16'h4e20
`define OC_CYC           16'h0a00
`define MIN_ON_CYC       6'h28

// =====================================================================
// Register offsets
`define REG_CTRL         4'h0
`define REG_IN_USE       4'h1
`define REG_OPEN         4'h2
`define REG_SHORT        4'h3
`define REG_STATUS       4'h4

// Control field positions and reset value
`define CTRL_OPEN_EN     0
`define CTRL_SHORT_EN    1
`define CTRL_RESET       8'h03

// Status field positions
`define ST_OC_LATCH      0
`define ST_TH_LATCH      1
`define ST_OVP           2
`define ST_ALL_OPEN      3
`define ST_BOOST         4
`define ST_NORMAL        5

`endif

// >>> design/string_channel.v
// One LED string: usage capture, open and short fault flags, source enable.
// Assumes all inputs are synchronous to clk_sys.
`include "led_seq_consts.vh"

module string_channel (
   input  wire clk_sys,
   input  wire rst_n,
   input  wire off,
   input  wire capture,
   input  wire detect_hi,
   input  wire check_open,
   input  wire check_short,
   input  wire sense_open,
   input  wire sense_short,
   input  wire other_low,
   input  wire drive,
   output reg  in_use_q,
   output reg  open_q,
   output reg  short_q,
   output reg  src_en_q
);

   // =================================================================
   // Usage and fault state
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         in_use_q <= 1'b0;
         open_q   <= 1'b0;
         short_q  <= 1'b0;
      end else if (off) begin
         in_use_q <= 1'b0;
         open_q   <= 1'b0;
         short_q  <= 1'b0;
      end else begin
         if (capture) begin
            in_use_q <= detect_hi;
         end
         if (check_open && in_use_q && sense_open) begin
            open_q <= 1'b1;
         end
         if (check_short && in_use_q && sense_short && other_low) begin
            short_q <= 1'b1;
         end
      end
   end

   // =================================================================
   // Source switch follows dimming, only for healthy strings
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         src_en_q <= 1'b0;
      end else begin
         src_en_q <= drive & in_use_q & ~open_q & ~short_q;
      end
   end

endmodule // string_channel

// >>> design/led_string_fault_sequencer.v
// Start-up sequencer, fault handling and dimming for six LED strings.
// Assumes analog comparators drive the sense inputs asynchronously and
// the host reaches status over a simple strobe register port.
`include "led_seq_consts.vh"

module led_string_fault_sequencer #(
   parameter [15:0] DIAG_CYC  = `DIAG_CYC,
   parameter [15:0] SOFT_CYC  = `SOFT_CYC,
   parameter [15:0] MINFB_CYC = `MINFB_CYC
) (
   input  wire       clk_sys,
   input  wire       rstn,
   input  wire       enable,
   input  wire       dim_pwm,
   input  wire [5:0] sense_open,
   input  wire [5:0] sense_short,
   input  wire [5:0] sense_low_reg,
   input  wire [5:0] sense_detect,
   input  wire       switch_overcurrent,
   input  wire       output_overvolt_sense,
   input  wire       thermal_trip,
   input  wire       osc_set,
   input  wire       comp_trip,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   output wire [5:0] string_src_en,
   output reg        pullup_en,
   output reg        boost_run,
   output reg        softstart_active,
   output reg        min_fb_ctrl,
   output reg        switch_gate,
   output reg        fault_flag_n_out,
   output reg        fault_flag_n_oe
);

   // =================================================================
   // States
   localparam [5:0] S_OFF   = 6'h01;
   localparam [5:0] S_DIAG  = 6'h02;
   localparam [5:0] S_SOFT  = 6'h04;
   localparam [5:0] S_MINFB = 6'h08;
   localparam [5:0] S_RUN   = 6'h10;
   localparam [5:0] S_LATCH = 6'h20;

   localparam [15:0] OC_CYC     = `OC_CYC;
   localparam [5:0]  MIN_ON_CYC = `MIN_ON_CYC;

   reg  [1:0]  rst_q;
   wire        rst_n;
   reg  [30:0] sync1_q;
   reg  [30:0] sync2_q;
   wire        en_s;
   wire        dim_s;
   wire [5:0]  open_s;
   wire [5:0]  short_s;
   wire [5:0]  low_s;
   wire [5:0]  det_s;
   wire        oc_s;
   wire        ovp_s;
   wire        th_s;
   wire        osc_s;
   wire        comp_s;
   reg  [5:0]  state_q;
   reg  [5:0]  state_d;
   reg  [15:0] tmr_q;
   reg  [15:0] oc_cnt_q;
   reg  [5:0]  on_cnt_q;
   reg         oc_lat_q;
   reg         th_lat_q;
   reg  [7:0]  ctrl_q;
   reg  [5:0]  other_low;
   wire [5:0]  in_use;
   wire [5:0]  open_f;
   wire [5:0]  short_f;
   wire        tmr_done;
   wire        oc_expire;
   wire        long_on;
   wire        detecting;
   wire        all_open;
   wire        off;
   wire        capture;
   wire        drive;
   integer     i;
   integer     j;

   // =================================================================
   // Reset release through two flip-flops
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // =================================================================
   // Two-stage synchroniser for every pin input except reset and the register port
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 31'h0;
         sync2_q <= 31'h0;
      end else begin
         sync1_q <= {enable, dim_pwm, sense_open, sense_short,
                     sense_low_reg, sense_detect, switch_overcurrent,
                     output_overvolt_sense, thermal_trip, osc_set,
                     comp_trip};
         sync2_q <= sync1_q;
      end
   end

   // Synchronised field split
   assign en_s    = sync2_q[30];
   assign dim_s   = sync2_q[29];
   assign open_s  = sync2_q[28:23];
   assign short_s = sync2_q[22:17];
   assign low_s   = sync2_q[16:11];
   assign det_s   = sync2_q[10:5];
   assign oc_s    = sync2_q[4];
   assign ovp_s   = sync2_q[3];
   assign th_s    = sync2_q[2];
   assign osc_s   = sync2_q[1];
   assign comp_s  = sync2_q[0];

   // =================================================================
   // Sequencer
   assign tmr_done  = (state_q == S_DIAG  && tmr_q == DIAG_CYC - 16'h1) ||
                      (state_q == S_SOFT  && tmr_q == SOFT_CYC - 16'h1) ||
                      (state_q == S_MINFB && tmr_q == MINFB_CYC - 16'h1);
   assign oc_expire = oc_s && (oc_cnt_q == OC_CYC - 16'h1);
   assign all_open  = (in_use != 6'h00) &&
                      ((in_use & ~(open_f | short_f)) == 6'h00);

   // Next state
   always @* begin
      state_d = state_q;
      case (state_q)
         S_OFF: begin
            if (en_s) begin
               state_d = S_DIAG;
            end
         end
         S_DIAG: begin
            if (tmr_done) begin
               state_d = S_SOFT;
            end
         end
         S_SOFT: begin
            if (tmr_done) begin
               state_d = S_MINFB;
            end
         end
         S_MINFB: begin
            if (tmr_done) begin
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            state_d = S_RUN;
         end
         S_LATCH: begin
            state_d = S_LATCH;
         end
         default: begin
            state_d = S_OFF;
         end
      endcase
      if (state_q != S_OFF && state_q != S_LATCH &&
          (th_s || oc_expire)) begin
         state_d = S_LATCH;
      end
      if (!en_s) begin
         state_d = S_OFF;
      end
   end

   // State and phase timer
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_OFF;
         tmr_q   <= 16'h0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) begin
            tmr_q <= 16'h0;
         end else if (tmr_q != 16'hffff) begin
            tmr_q <= tmr_q + 16'h1;
         end
      end
   end

   // =================================================================
   // Overcurrent fault timer and latches
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         oc_cnt_q <= 16'h0;
         oc_lat_q <= 1'b0;
         th_lat_q <= 1'b0;
      end else if (!en_s) begin
         oc_cnt_q <= 16'h0;
         oc_lat_q <= 1'b0;
         th_lat_q <= 1'b0;
      end else begin
         if (!oc_s || !boost_run) begin
            oc_cnt_q <= 16'h0;
         end else if (!oc_expire) begin
            oc_cnt_q <= oc_cnt_q + 16'h1;
         end
         if (boost_run && oc_expire) begin
            oc_lat_q <= 1'b1;
         end
         if (state_q != S_OFF && th_s) begin
            th_lat_q <= 1'b1;
         end
      end
   end

   // =================================================================
   // Dimming on-time qualifier for fault detection
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt_q <= 6'h0;
      end else if (!dim_s) begin
         on_cnt_q <= 6'h0;
      end else if (on_cnt_q != MIN_ON_CYC) begin
         on_cnt_q <= on_cnt_q + 6'h1;
      end
   end
   assign long_on   = (on_cnt_q == MIN_ON_CYC);
   assign detecting = long_on && (state_q == S_MINFB || state_q == S_RUN);

   // =================================================================
   // Per-string channels
   assign off     = (state_q == S_OFF);
   assign capture = (state_q == S_DIAG) && tmr_done;
   assign drive   = dim_s && (state_q == S_MINFB || state_q == S_RUN);

   // Any other in-use string below regulation plus margin
   always @* begin
      other_low = 6'h00;
      for (i = 0; i < 6; i = i + 1) begin
         for (j = 0; j < 6; j = j + 1) begin
            if (j != i && in_use[j] && low_s[j]) begin
               other_low[i] = 1'b1;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_str
         string_channel u_chan (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .off         (off),
            .capture     (capture),
            .detect_hi   (det_s[g]),
            .check_open  (detecting && ctrl_q[`CTRL_OPEN_EN]),
            .check_short (detecting && ctrl_q[`CTRL_SHORT_EN]),
            .sense_open  (open_s[g]),
            .sense_short (short_s[g]),
            .other_low   (other_low[g]),
            .drive       (drive),
            .in_use_q    (in_use[g]),
            .open_q      (open_f[g]),
            .short_q     (short_f[g]),
            .src_en_q    (string_src_en[g])
         );
      end
   endgenerate

   // =================================================================
   // Phase outputs and boost switch gate
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pullup_en        <= 1'b0;
         boost_run        <= 1'b0;
         softstart_active <= 1'b0;
         min_fb_ctrl      <= 1'b0;
         switch_gate      <= 1'b0;
      end else begin
         pullup_en        <= (state_d == S_DIAG);
         boost_run        <= (state_d == S_SOFT || state_d == S_MINFB ||
                              state_d == S_RUN) && !all_open;
         softstart_active <= (state_d == S_SOFT);
         min_fb_ctrl      <= (state_d == S_MINFB);
         if (!boost_run || ovp_s || oc_s || comp_s) begin
            switch_gate <= 1'b0;
         end else if (osc_s) begin
            switch_gate <= 1'b1;
         end
      end
   end

   // =================================================================
   // Open-drain fault flag, pulled low while a device fault stands
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fault_flag_n_out <= 1'b0;
         fault_flag_n_oe  <= 1'b0;
      end else begin
         fault_flag_n_out <= 1'b0;
         fault_flag_n_oe  <= oc_lat_q | th_lat_q | (ovp_s & ~off) |
                             (all_open & ~off);
      end
   end

   // =================================================================
   // Register port: one write register, read data a cycle later
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `CTRL_RESET;
      end else if (reg_wr && reg_addr == `REG_CTRL) begin
         ctrl_q <= {6'h00, reg_wdata[1:0]};
      end
   end

   // Read mux
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL:   reg_rdata <= ctrl_q;
            `REG_IN_USE: reg_rdata <= {2'b00, in_use};
            `REG_OPEN:   reg_rdata <= {2'b00, open_f};
            `REG_SHORT:  reg_rdata <= {2'b00, short_f};
            `REG_STATUS: begin
               reg_rdata <= 8'h00;
               reg_rdata[`ST_OC_LATCH] <= oc_lat_q;
               reg_rdata[`ST_TH_LATCH] <= th_lat_q;
               reg_rdata[`ST_OVP]      <= ovp_s;
               reg_rdata[`ST_ALL_OPEN] <= all_open;
               reg_rdata[`ST_BOOST]    <= boost_run;
               reg_rdata[`ST_NORMAL]   <= (state_q == S_RUN);
            end
            default:     reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // led_string_fault_sequencer

// >>> sim/led_string_fault_sequencer_sva.sv
// Port checker for the LED string fault sequencer.
// Assumes every phase count of the instance is at least 8 cycles.
module led_string_fault_sequencer_sva (
   input wire       clk_sys,
   input wire       rstn,
   input wire       dim_pwm,
   input wire       switch_overcurrent,
   input wire       output_overvolt_sense,
   input wire       thermal_trip,
   input wire [5:0] string_src_en,
   input wire       pullup_en,
   input wire       boost_run,
   input wire       softstart_active,
   input wire       min_fb_ctrl,
   input wire       switch_gate,
   input wire       fault_flag_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================================
   // Sequence, dimming and fault timing
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   property p_dim_off;
      !dim_pwm [*5] |-> string_src_en == 6'h00;
   endproperty
   a_dim_off: assert property (p_dim_off)
      else $error("source on while dimming low");
   property p_pullup;
      $rose(pullup_en) |-> (pullup_en && !boost_run) [*8];
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up phase short or converter on");
   property p_soft;
      $rose(softstart_active) |-> (softstart_active && boost_run) [*8];
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft-start cut short");
   property p_minsense;
      $rose(min_fb_ctrl) |-> $past(softstart_active) ##0 min_fb_ctrl [*8];
   endproperty
   a_minsense: assert property (p_minsense)
      else $error("minimum-sense phase out of order");
   property p_thermal;
      thermal_trip [*6] |-> !boost_run && string_src_en == 6'h00;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("thermal trip did not stop outputs");
   property p_overvolt;
      output_overvolt_sense [*5] ##0 boost_run |->
         fault_flag_n_oe && !switch_gate;
   endproperty
   a_overvolt: assert property (p_overvolt)
      else $error("overvoltage did not stop switch");
   property p_curlim;
      switch_overcurrent [*5] |-> !switch_gate;
   endproperty
   a_curlim: assert property (p_curlim)
      else $error("switch on at current limit");
   property p_gate_run;
      !boost_run [*3] |-> !switch_gate;
   endproperty
   a_gate_run: assert property (p_gate_run)
      else $error("switch on with converter stopped");
endmodule // led_string_fault_sequencer_sva

bind led_string_fault_sequencer led_string_fault_sequencer_sva
   i_led_string_fault_sequencer_sva (
   .clk_sys(clk_sys), .rstn(rstn), .dim_pwm(dim_pwm),
   .switch_overcurrent(switch_overcurrent),
   .output_overvolt_sense(output_overvolt_sense),
   .thermal_trip(thermal_trip), .string_src_en(string_src_en),
   .pullup_en(pullup_en), .boost_run(boost_run),
   .softstart_active(softstart_active), .min_fb_ctrl(min_fb_ctrl),
   .switch_gate(switch_gate), .fault_flag_n_oe(fault_flag_n_oe));

// >>> sim/led_string_model.sv
// Far-side model: six LED strings and the converter oscillator.
// Assumes the bench sets the wiring of each string through cfg inputs.
module led_string_model (
   input  wire       clk_sys,
   input  wire [5:0] src_en,
   input  wire       pullup_en,
   input  wire [5:0] grounded,
   input  wire [5:0] opened,
   input  wire [5:0] shorted,
   output wire [5:0] detect,
   output wire [5:0] below_open,
   output wire [5:0] above_short,
   output wire [5:0] low_reg,
   output wire       osc_set,
   output wire       comp_trip
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ph_q = 3'h0;
   // Pull-up lifts every pin not tied to ground
   assign detect = pullup_en ? ~grounded : 6'h00;
   // Grounded or broken strings sit near zero
   assign below_open = grounded | (src_en & opened);
   assign above_short = src_en & shorted;
   assign low_reg = grounded | (src_en & ~shorted);
   // Oscillator start at phase 0, current peak at phase 4
   always @(posedge clk_sys) begin
      ph_q <= ph_q + 3'h1;
   end
   assign osc_set = ph_q == 3'h0;
   assign comp_trip = ph_q == 3'h4;
endmodule // led_string_model

// >>> sim/led_string_fault_sequencer_tb.sv
// Self-checking bench for the LED string fault sequencer.
// Assumes short phase counts and the string model on the sense side.
`include "led_seq_consts.vh"
module led_string_fault_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SUM = 80;
   localparam int DIM = 0, OVV = 1, OVC = 2, THM = 3, ENA = 4;
   logic       clk_sys, rstn, enable, dim_pwm, overcur, overvolt, thermal;
   logic       reg_wr, reg_rd, pullup_en, boost_run, soft_on, minsense;
   logic       osc_set, comp_trip, switch_gate, flag_out, flag_oe, seen;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [5:0] src_en, gnd_cfg, open_cfg, short_cfg;
   logic [5:0] detect, below_open, above_short, low_reg;
   int         num_errors = 0;
   int         n_compared = 0;
   int         i;
   // Open-drain flag wire with pull-up
   wire        fault_flag_n = flag_oe ? flag_out : 1'b1;

   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   led_string_fault_sequencer #(.DIAG_CYC(16'h0014),
      .SOFT_CYC(16'h0028), .MINFB_CYC(16'h0014))
      i_led_string_fault_sequencer (
      .clk_sys(clk_sys), .rstn(rstn), .enable(enable), .dim_pwm(dim_pwm),
      .sense_open(below_open), .sense_short(above_short),
      .sense_low_reg(low_reg), .sense_detect(detect),
      .switch_overcurrent(overcur), .output_overvolt_sense(overvolt),
      .thermal_trip(thermal), .osc_set(osc_set), .comp_trip(comp_trip),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .string_src_en(src_en),
      .pullup_en(pullup_en), .boost_run(boost_run),
      .softstart_active(soft_on), .min_fb_ctrl(minsense),
      .switch_gate(switch_gate), .fault_flag_n_out(flag_out),
      .fault_flag_n_oe(flag_oe));
   led_string_model i_led_string_model (
      .clk_sys(clk_sys), .src_en(src_en), .pullup_en(pullup_en),
      .grounded(gnd_cfg), .opened(open_cfg), .shorted(short_cfg),
      .detect(detect), .below_open(below_open),
      .above_short(above_short), .low_reg(low_reg),
      .osc_set(osc_set), .comp_trip(comp_trip));

   // ====================================
   // Tasks
   task automatic chk(input string w, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk($sformatf("register %h", a), e, reg_rdata);
   endtask
   task automatic drv(input int s, input logic v, input int n);
      @(posedge clk_sys);
      case (s)
         DIM: dim_pwm <= v;
         OVV: overvolt <= v;
         OVC: overcur <= v;
         THM: thermal <= v;
         default: enable <= v;
      endcase
      cyc(n);
      #1;
   endtask
   task automatic start();
      @(posedge clk_sys);
      enable <= 1'b1;
      for (i = 0; i < 300 && !(boost_run === 1'b1 && soft_on === 1'b0
           && minsense === 1'b0); i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk("startup cycles", 8'h01, {7'h0, i >= SUM && i <= SUM + 10});
      rd(4'h1, 8'h1f);
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      cyc(20000);
      num_errors++;
      $display("ERROR watchdog expected finish seen timeout");
      stop_test();
   end

   // ====================================
   // Tests
   initial begin
      {rstn, enable, dim_pwm, overcur, overvolt, thermal} = 6'h00;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
      {gnd_cfg, open_cfg, short_cfg} = {6'h20, 6'h00, 6'h00};
      cyc(10);
      rstn <= 1'b1;
      cyc(3);
      rd(4'h0, 8'h03);
      wr(4'h0, 8'hff);
      rd(4'h0, 8'h03);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h03);
      wr(4'h1, 8'h3f);
      rd(4'h1, 8'h00);
      rd(4'hf, 8'h00);
      $display("test registers done");
      start();
      rd(4'h4, 8'h30);
      drv(DIM, 1'b1, 6);
      chk("src_en", 8'h1f, {2'h0, src_en});
      drv(DIM, 1'b0, 6);
      chk("src_en", 8'h00, {2'h0, src_en});
      $display("test startup done");
      open_cfg = 6'h01;
      drv(DIM, 1'b1, 30);
      drv(DIM, 1'b0, 10);
      rd(4'h2, 8'h00);
      drv(DIM, 1'b1, 60);
      chk("src_en", 8'h1e, {2'h0, src_en});
      rd(4'h2, 8'h01);
      short_cfg = 6'h04;
      drv(DIM, 1'b0, 10);
      drv(DIM, 1'b1, 60);
      chk("src_en", 8'h1a, {2'h0, src_en});
      rd(4'h3, 8'h04);
      chk("fault_flag_n", 8'h01, {7'h0, fault_flag_n});
      drv(DIM, 1'b0, 10);
      gnd_cfg = 6'h3f;
      rd(4'h1, 8'h1f);
      gnd_cfg = 6'h20;
      $display("test string faults done");
      drv(OVV, 1'b1, 10);
      chk("fault_flag_n", 8'h00, {7'h0, fault_flag_n});
      chk("switch_gate", 8'h00, {7'h0, switch_gate});
      drv(OVV, 1'b0, 10);
      seen = 1'b0;
      repeat (16) @(posedge clk_sys) seen |= switch_gate;
      chk("switch_gate seen", 8'h01, {7'h0, seen});
      chk("fault_flag_n", 8'h01, {7'h0, fault_flag_n});
      $display("test overvoltage done");
      drv(OVC, 1'b1, `OC_CYC - 500);
      drv(OVC, 1'b0, 5);
      chk("boost_run", 8'h01, {7'h0, boost_run});
      drv(OVC, 1'b1, `OC_CYC + 40);
      drv(OVC, 1'b0, 5);
      chk("boost_run", 8'h00, {7'h0, boost_run});
      chk("fault_flag_n", 8'h00, {7'h0, fault_flag_n});
      rd(4'h4, 8'h01);
      drv(ENA, 1'b0, 5);
      rd(4'h4, 8'h00);
      rd(4'h2, 8'h00);
      {open_cfg, short_cfg} = 12'h000;
      $display("test overcurrent done");
      start();
      drv(DIM, 1'b1, 10);
      drv(THM, 1'b1, 6);
      drv(THM, 1'b0, 20);
      chk("src_en", 8'h00, {2'h0, src_en});
      chk("boost_run", 8'h00, {7'h0, boost_run});
      chk("fault_flag_n", 8'h00, {7'h0, fault_flag_n});
      rd(4'h4, 8'h02);
      $display("test thermal done");
      drv(ENA, 1'b0, 5);
      start();
      open_cfg = 6'h1f;
      drv(DIM, 1'b1, 60);
      chk("boost_run", 8'h00, {7'h0, boost_run});
      chk("fault_flag_n", 8'h00, {7'h0, fault_flag_n});
      rd(4'h4, 8'h28);
      $display("test all open done");
      stop_test();
   end
endmodule // led_string_fault_sequencer_tb
